// ### verilog/ckg_regs.svh
// register map, field positions and reset values of the clock gate block
//
// Overview of operation
// - chop-timer gate bit 2 set stops amplifier chop clock; reset 0x0004 starts it off
// - chop-timer gate bit 1 set stops sleep/wake-up timer clock; resets to 0
// - main gate bit 5 set stops front-end control clock; resets to 0, clock runs
// - oscillator control write accepted only after key 0xcb14 written to unlock key
// - a write to any other register after unlocking relocks the protection
// - control bit 10 reads 1 once crystal oscillator enabled and stable; resets 0
// - control bit 9 reads 1 once internal high-frequency oscillator enabled and stable
// - stable flags catch first settling after each enable; later loss of stability not reported
// - control bits 2/1/0 enable crystal, hf internal, lf internal; resets 0/1/1
// - control bit 8 reads 1 once low-frequency oscillator enabled and stable
`ifndef CKG_REGS_SVH
`define CKG_REGS_SVH

// ************************************************************
// offsets (byte addresses)
// ************************************************************
`define CKG_MAIN_GATE_OFS     32'h0000_0410
`define CKG_UNLOCK_KEY_OFS    32'h0000_0a0c
`define CKG_OSC_CONTROL_OFS   32'h0000_0a10
`define CKG_CHOP_GATE_OFS     32'h0000_0a70
`define CKG_IRQ_STATUS_OFS    32'h0000_0a80
`define CKG_IRQ_ENABLE_OFS    32'h0000_0a84
`define CKG_IRQ_CLEAR_OFS     32'h0000_0a88

// ************************************************************
// fields
// ************************************************************
`define CKG_CHOP_AMP_OFF_BIT  2
`define CKG_CHOP_SLEEP_OFF_BIT 1
`define CKG_CHOP_WMASK        16'h0007
`define CKG_MAIN_FE_OFF_BIT   5
`define CKG_MAIN_WMASK        16'h03ff
`define CKG_OSC_XTAL_OK_BIT   10
`define CKG_OSC_HF_OK_BIT     9
`define CKG_OSC_LF_OK_BIT     8
`define CKG_OSC_XTAL_EN_BIT   2
`define CKG_OSC_HF_EN_BIT     1
`define CKG_OSC_LF_EN_BIT     0
`define CKG_UNLOCK_VALUE      16'hcb14
`define CKG_IRQ_W             4
`define CKG_IRQ_XTAL_BIT      0
`define CKG_IRQ_HF_BIT        1
`define CKG_IRQ_LF_BIT        2
`define CKG_IRQ_REJECT_BIT    3

// ************************************************************
// reset values
// ************************************************************
`define CKG_CHOP_GATE_RST     16'h0004
`define CKG_MAIN_GATE_RST     16'h01c0
`define CKG_UNLOCK_KEY_RST    16'h0000
`define CKG_OSC_EN_RST        3'h3

`endif

// ### verilog/ckg_pkg.sv
// types shared by the clock gate block
package ckg_pkg;
  typedef enum logic [1:0] {
    CKG_LOCKED   = 2'b01,
    CKG_UNLOCKED = 2'b10
  } ckg_lock_t;
endpackage : ckg_pkg

// ### verilog/ckg_osc_flag.sv
// sticky oscillator stable flag with a one-cycle settle pulse
`timescale 1ns/1ps
module ckg_osc_flag (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic osc_on,
  input  wire logic osc_ready,
  output logic      stable_flag,
  output logic      settle_pulse
);
  logic next_stable_flag;
  logic next_settle_pulse;

  // only a disable clears the flag, never a lost ready
  always_comb begin
    next_stable_flag  = osc_on & (stable_flag | osc_ready);
    next_settle_pulse = next_stable_flag & ~stable_flag;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stable_flag  <= 1'b0;
      settle_pulse <= 1'b0;
    end else begin
      stable_flag  <= next_stable_flag;
      settle_pulse <= next_settle_pulse;
    end
  end
endmodule : ckg_osc_flag

// ### verilog/ckg_gate_en.sv
// registered clock enables from disable bits
`timescale 1ns/1ps
module ckg_gate_en #(
  parameter int W = 3
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] clk_off,
  output logic      [W-1:0] clk_en
);
  logic [W-1:0] next_clk_en;

  generate
    if (W < 1) begin : g_chk
      $error("ckg_gate_en: W must be at least 1");
    end
  endgenerate

  always_comb begin
    next_clk_en = ~clk_off;
  end

  // all enables start low; they follow the bits one cycle after reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clk_en <= '0;
    end else begin
      clk_en <= next_clk_en;
    end
  end
endmodule : ckg_gate_en

// ### verilog/ckg_top.sv
// clock gate and key protected oscillator control with apb registers
`timescale 1ns/1ps
`include "ckg_regs.svh"
module ckg_top #(
  parameter int PADDR_W = 32
) (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              crystal_ready,
  input  wire logic              hf_internal_ready,
  input  wire logic              lf_internal_ready,
  output logic                   amp_chop_clk_en,
  output logic                   sleep_timer_clk_en,
  output logic                   frontend_ctrl_clk_en,
  output logic                   crystal_osc_on,
  output logic                   hf_internal_osc_on,
  output logic                   lf_internal_osc_on,
  output logic      [9:0]        main_gate_cfg,
  output ckg_pkg::ckg_lock_t     lock_state,
  output logic                   irq
);
  import ckg_pkg::*;

  generate
    if (PADDR_W < 12) begin : g_chk
      $error("ckg_top: PADDR_W must be at least 12");
    end
  endgenerate

  // ************************************************************
  // apb decode
  // ************************************************************
  logic [31:0] addr32;
  logic        setup;
  logic        wr_acc;
  logic        hit;
  logic        hit_chop, hit_main, hit_key, hit_osc;
  logic        hit_ist, hit_ien, hit_icl;

  always_comb begin
    addr32   = 32'(paddr);
    hit_chop = (addr32 == `CKG_CHOP_GATE_OFS);
    hit_main = (addr32 == `CKG_MAIN_GATE_OFS);
    hit_key  = (addr32 == `CKG_UNLOCK_KEY_OFS);
    hit_osc  = (addr32 == `CKG_OSC_CONTROL_OFS);
    hit_ist  = (addr32 == `CKG_IRQ_STATUS_OFS);
    hit_ien  = (addr32 == `CKG_IRQ_ENABLE_OFS);
    hit_icl  = (addr32 == `CKG_IRQ_CLEAR_OFS);
    hit      = hit_chop | hit_main | hit_key | hit_osc | hit_ist | hit_ien | hit_icl;
    setup    = psel & ~penable;
    // writes land on the access edge, which is the only edge with pready high
    wr_acc   = psel & penable & pready & pwrite;
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [15:0]           chop_timer_gate_reg, next_chop_timer_gate_reg;
  logic [15:0]           main_gate_reg, next_main_gate_reg;
  logic [15:0]           osc_unlock_key, next_osc_unlock_key;
  logic [2:0]            osc_en, next_osc_en;
  ckg_lock_t             lock_q, next_lock_q;
  logic                  reject_ev, next_reject_ev;
  logic [`CKG_IRQ_W-1:0] irq_status, next_irq_status;
  logic [`CKG_IRQ_W-1:0] irq_enable, next_irq_enable;
  logic                  next_irq;
  logic                  xtal_ok, hf_ok, lf_ok;
  logic                  xtal_rise, hf_rise, lf_rise;
  logic [`CKG_IRQ_W-1:0] ev;
  logic [`CKG_IRQ_W-1:0] clr;

  always_comb begin
    next_chop_timer_gate_reg = chop_timer_gate_reg;
    next_main_gate_reg       = main_gate_reg;
    next_osc_unlock_key      = osc_unlock_key;
    next_osc_en              = osc_en;
    next_lock_q              = lock_q;
    next_reject_ev           = 1'b0;
    if (wr_acc && hit) begin
      // any mapped write relocks, osc writes too; only a good key below unlocks
      next_lock_q = CKG_LOCKED;
      if (hit_chop) begin
        next_chop_timer_gate_reg = pwdata[15:0] & `CKG_CHOP_WMASK;
      end
      if (hit_main) begin
        next_main_gate_reg = pwdata[15:0] & `CKG_MAIN_WMASK;
      end
      if (hit_key) begin
        next_osc_unlock_key = pwdata[15:0];
        if (pwdata[15:0] == `CKG_UNLOCK_VALUE) begin
          next_lock_q = CKG_UNLOCKED;
        end
      end
      if (hit_osc) begin
        if (lock_q == CKG_UNLOCKED) begin
          next_osc_en = pwdata[2:0];
        end else begin
          next_reject_ev = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      chop_timer_gate_reg <= `CKG_CHOP_GATE_RST;
      main_gate_reg       <= `CKG_MAIN_GATE_RST;
      osc_unlock_key      <= `CKG_UNLOCK_KEY_RST;
      osc_en              <= `CKG_OSC_EN_RST;
      lock_q              <= CKG_LOCKED;
      reject_ev           <= 1'b0;
    end else begin
      chop_timer_gate_reg <= next_chop_timer_gate_reg;
      main_gate_reg       <= next_main_gate_reg;
      osc_unlock_key      <= next_osc_unlock_key;
      osc_en              <= next_osc_en;
      lock_q              <= next_lock_q;
      reject_ev           <= next_reject_ev;
    end
  end

  // ************************************************************
  // oscillator flags and clock enables
  // ************************************************************
  ckg_osc_flag u_xtal (
    .clk_sys      (clk_sys),
    .nrst         (nrst),
    .osc_on       (osc_en[`CKG_OSC_XTAL_EN_BIT]),
    .osc_ready    (crystal_ready),
    .stable_flag  (xtal_ok),
    .settle_pulse (xtal_rise)
  );

  ckg_osc_flag u_hf (
    .clk_sys      (clk_sys),
    .nrst         (nrst),
    .osc_on       (osc_en[`CKG_OSC_HF_EN_BIT]),
    .osc_ready    (hf_internal_ready),
    .stable_flag  (hf_ok),
    .settle_pulse (hf_rise)
  );

  ckg_osc_flag u_lf (
    .clk_sys      (clk_sys),
    .nrst         (nrst),
    .osc_on       (osc_en[`CKG_OSC_LF_EN_BIT]),
    .osc_ready    (lf_internal_ready),
    .stable_flag  (lf_ok),
    .settle_pulse (lf_rise)
  );

  ckg_gate_en #(.W(3)) u_gate (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clk_off ({main_gate_reg[`CKG_MAIN_FE_OFF_BIT],
               chop_timer_gate_reg[`CKG_CHOP_SLEEP_OFF_BIT],
               chop_timer_gate_reg[`CKG_CHOP_AMP_OFF_BIT]}),
    .clk_en  ({frontend_ctrl_clk_en, sleep_timer_clk_en, amp_chop_clk_en})
  );

  // ************************************************************
  // interrupts
  // ************************************************************
  always_comb begin
    ev = '0;
    ev[`CKG_IRQ_XTAL_BIT]   = xtal_rise;
    ev[`CKG_IRQ_HF_BIT]     = hf_rise;
    ev[`CKG_IRQ_LF_BIT]     = lf_rise;
    ev[`CKG_IRQ_REJECT_BIT] = reject_ev;
    clr = '0;
    if (wr_acc && hit_icl) begin
      clr = pwdata[`CKG_IRQ_W-1:0];
    end
    next_irq_enable = irq_enable;
    if (wr_acc && hit_ien) begin
      next_irq_enable = pwdata[`CKG_IRQ_W-1:0];
    end
    // a new event beats a clear in the same cycle
    next_irq_status = (irq_status & ~clr) | ev;
    next_irq        = |(next_irq_status & next_irq_enable);
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irq_status <= '0;
      irq_enable <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      irq        <= next_irq;
    end
  end

  // ************************************************************
  // apb answer and outputs
  // ************************************************************
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [15:0] osc_view;

  always_comb begin
    osc_view                       = {13'h0000, osc_en};
    osc_view[`CKG_OSC_XTAL_OK_BIT] = xtal_ok;
    osc_view[`CKG_OSC_HF_OK_BIT]   = hf_ok;
    osc_view[`CKG_OSC_LF_OK_BIT]   = lf_ok;
    next_prdata  = prdata;
    next_pready  = setup;
    next_pslverr = setup & ~hit;
    if (setup) begin
      next_prdata = 32'h0000_0000;
      if (!pwrite) begin
        case (1'b1)
          hit_chop: next_prdata = {16'h0000, chop_timer_gate_reg};
          hit_main: next_prdata = {16'h0000, main_gate_reg};
          hit_key:  next_prdata = {16'h0000, osc_unlock_key};
          hit_osc:  next_prdata = {16'h0000, osc_view};
          hit_ist:  next_prdata = {28'h0000000, irq_status};
          hit_ien:  next_prdata = {28'h0000000, irq_enable};
          default:  next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prdata             <= 32'h0000_0000;
      pready             <= 1'b0;
      pslverr            <= 1'b0;
      crystal_osc_on     <= 1'b0;
      hf_internal_osc_on <= 1'b1;
      lf_internal_osc_on <= 1'b1;
      main_gate_cfg      <= 10'(`CKG_MAIN_GATE_RST);
      lock_state         <= CKG_LOCKED;
    end else begin
      prdata             <= next_prdata;
      pready             <= next_pready;
      pslverr            <= next_pslverr;
      crystal_osc_on     <= next_osc_en[`CKG_OSC_XTAL_EN_BIT];
      hf_internal_osc_on <= next_osc_en[`CKG_OSC_HF_EN_BIT];
      lf_internal_osc_on <= next_osc_en[`CKG_OSC_LF_EN_BIT];
      main_gate_cfg      <= next_main_gate_reg[9:0];
      lock_state         <= next_lock_q;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_chop_gate;
    chop_timer_gate_reg[`CKG_CHOP_AMP_OFF_BIT] ##1
      chop_timer_gate_reg[`CKG_CHOP_AMP_OFF_BIT] |-> !amp_chop_clk_en;
  endproperty
  a_chop_gate: assert property (p_chop_gate) else $error("chop clock runs while off");

  property p_sleep_gate;
    $changed(chop_timer_gate_reg[`CKG_CHOP_SLEEP_OFF_BIT]) |=>
      sleep_timer_clk_en == !$past(chop_timer_gate_reg[`CKG_CHOP_SLEEP_OFF_BIT]);
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("sleep clock enable wrong");

  property p_fe_gate;
    wr_acc && hit_main |=> ##1 frontend_ctrl_clk_en == !$past(pwdata[`CKG_MAIN_FE_OFF_BIT], 2);
  endproperty
  a_fe_gate: assert property (p_fe_gate) else $error("front-end clock enable wrong");

  property p_locked_ignored;
    wr_acc && hit_osc && lock_q == CKG_LOCKED |=>
      $stable(osc_en) && reject_ev ##1 irq_status[`CKG_IRQ_REJECT_BIT];
  endproperty
  a_locked_ignored: assert property (p_locked_ignored) else $error("locked write took effect");

  property p_relock_other;
    wr_acc && (hit_chop || hit_main || hit_ien || hit_icl || hit_ist) |=>
      lock_q == CKG_LOCKED;
  endproperty
  a_relock_other: assert property (p_relock_other) else $error("not relocked");

  property p_xtal_flag;
    xtal_ok |-> $past(osc_en[`CKG_OSC_XTAL_EN_BIT]) &&
      ($past(xtal_ok) || $past(crystal_ready));
  endproperty
  a_xtal_flag: assert property (p_xtal_flag) else $error("crystal flag without enable");

  property p_hf_rise;
    $rose(hf_ok) |-> $past(hf_internal_ready) && $past(osc_en[`CKG_OSC_HF_EN_BIT]);
  endproperty
  a_hf_rise: assert property (p_hf_rise) else $error("hf flag rose without ready");

  property p_flag_sticky;
    lf_ok && osc_en[`CKG_OSC_LF_EN_BIT] ##1 osc_en[`CKG_OSC_LF_EN_BIT] |-> lf_ok;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("lf flag dropped while on");

  property p_osc_write;
    wr_acc && hit_osc && lock_q == CKG_UNLOCKED |=>
      osc_en == $past(pwdata[2:0]) ##1 crystal_osc_on == $past(pwdata[2], 2);
  endproperty
  a_osc_write: assert property (p_osc_write) else $error("unlocked write lost");

  property p_lf_flag;
    lf_ok |-> $past(lf_internal_osc_on) &&
      ($past(lf_ok) || $past(lf_internal_ready));
  endproperty
  a_lf_flag: assert property (p_lf_flag) else $error("lf flag without enable");

  property p_relock_after;
    wr_acc && hit_osc |=> (lock_q == CKG_LOCKED) [*2];
  endproperty
  a_relock_after: assert property (p_relock_after) else $error("still unlocked");

  c_unlock_write: cover property (wr_acc && hit_key ##[1:20] wr_acc && hit_osc && lock_q == CKG_UNLOCKED);
  c_reject: cover property (reject_ev);
  c_xtal_settle: cover property ($rose(xtal_ok));
  c_irq: cover property ($rose(irq));
endmodule : ckg_top

// ### verilog/ckg_top_dummy_guard.sv
// spare design unit; it holds no module
`timescale 1ns/1ps

// ### sim/tb_ckg_top.sv
// self-checking apb testbench for the clock gate and oscillator key block
`timescale 1ns/1ps
`include "ckg_regs.svh"
module tb_ckg_top;
  import ckg_pkg::*;
  logic              clk_sys;
  logic              nrst;
  logic [31:0]       paddr;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              crystal_ready;
  logic              hf_internal_ready;
  logic              lf_internal_ready;
  logic              amp_chop_clk_en;
  logic              sleep_timer_clk_en;
  logic              frontend_ctrl_clk_en;
  logic              crystal_osc_on;
  logic              hf_internal_osc_on;
  logic              lf_internal_osc_on;
  logic [9:0]        main_gate_cfg;
  ckg_lock_t         lock_state;
  logic              irq;
  int                fail_count;
  int                comparisons;
  logic [31:0]       rd;
  logic              er;

  ckg_top #(.PADDR_W(32)) ckg_top_i (
    .clk_sys(clk_sys), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_ready(crystal_ready), .hf_internal_ready(hf_internal_ready),
    .lf_internal_ready(lf_internal_ready), .amp_chop_clk_en(amp_chop_clk_en),
    .sleep_timer_clk_en(sleep_timer_clk_en), .frontend_ctrl_clk_en(frontend_ctrl_clk_en),
    .crystal_osc_on(crystal_osc_on), .hf_internal_osc_on(hf_internal_osc_on),
    .lf_internal_osc_on(lf_internal_osc_on), .main_gate_cfg(main_gate_cfg),
    .lock_state(lock_state), .irq(irq)
  );

  // ************************************************************
  // clock and watchdog
  // ************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    #200000;
    fail_count = fail_count + 1;
    complete_run();
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic complete_run();
    $display("errors %0d of %0d comparisons", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // slave answers with no fixed latency assumed; bounded by the watchdog only
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd, er);
  endtask : wr

  task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000, rd, er);
    chk(what, rd, exp);
  endtask : rchk

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    fail_count = 0;
    comparisons = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    crystal_ready = 1'b0;
    hf_internal_ready = 1'b0;
    lf_internal_ready = 1'b0;
    idle(2);
    nrst <= 1'b1;
    rchk("chop_gate", `CKG_CHOP_GATE_OFS, 32'h0000_0004);
    rchk("main_gate", `CKG_MAIN_GATE_OFS, 32'h0000_01c0);
    rchk("unlock_key", `CKG_UNLOCK_KEY_OFS, 32'h0000_0000);
    rchk("osc_control", `CKG_OSC_CONTROL_OFS, 32'h0000_0003);
    chk("amp_en", {31'h0, amp_chop_clk_en}, 32'h0);
    chk("sleep_en", {31'h0, sleep_timer_clk_en}, 32'h1);
    chk("fe_en", {31'h0, frontend_ctrl_clk_en}, 32'h1);
    chk("hf_lf_on", {30'h0, hf_internal_osc_on, lf_internal_osc_on}, 32'h3);
    xfer(1'b0, 32'h0000_0ff0, 32'h0, rd, er);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    // locked write must be dropped
    wr(`CKG_OSC_CONTROL_OFS, 32'h0000_0004);
    rchk("osc_locked", `CKG_OSC_CONTROL_OFS, 32'h0000_0003);
    rchk("irq_status_rej", `CKG_IRQ_STATUS_OFS, 32'h0000_0008);
    chk("xtal_on_locked", {31'h0, crystal_osc_on}, 32'h0);
    // key then osc write, with an idle cycle and a read in between
    wr(`CKG_UNLOCK_KEY_OFS, 32'h0000_cb14);
    idle(1);
    chk("lock_open", {30'h0, lock_state}, {30'h0, CKG_UNLOCKED});
    rchk("key_read", `CKG_UNLOCK_KEY_OFS, 32'h0000_cb14);
    wr(`CKG_OSC_CONTROL_OFS, 32'h0000_0007);
    rchk("osc_unlocked", `CKG_OSC_CONTROL_OFS, 32'h0000_0007);
    chk("xtal_on", {31'h0, crystal_osc_on}, 32'h1);
    chk("lock_again", {30'h0, lock_state}, {30'h0, CKG_LOCKED});
    wr(`CKG_OSC_CONTROL_OFS, 32'h0000_0000);
    rchk("osc_relocked", `CKG_OSC_CONTROL_OFS, 32'h0000_0007);
    // intervening write to another register relocks
    wr(`CKG_UNLOCK_KEY_OFS, 32'h0000_cb14);
    wr(`CKG_MAIN_GATE_OFS, 32'h0000_01c9);
    wr(`CKG_OSC_CONTROL_OFS, 32'h0000_0000);
    rchk("osc_other_wr", `CKG_OSC_CONTROL_OFS, 32'h0000_0007);
    wr(`CKG_UNLOCK_KEY_OFS, 32'h0000_1234);
    wr(`CKG_OSC_CONTROL_OFS, 32'h0000_0000);
    rchk("osc_bad_key", `CKG_OSC_CONTROL_OFS, 32'h0000_0007);
    chk("main_cfg", {22'h0, main_gate_cfg}, 32'h0000_01c9);
    // front-end clock gate
    wr(`CKG_MAIN_GATE_OFS, 32'h0000_01e9);
    idle(2);
    chk("fe_off", {31'h0, frontend_ctrl_clk_en}, 32'h0);
    rchk("main_rd", `CKG_MAIN_GATE_OFS, 32'h0000_01e9);
    wr(`CKG_MAIN_GATE_OFS, 32'h0000_01c9);
    idle(2);
    chk("fe_on", {31'h0, frontend_ctrl_clk_en}, 32'h1);
    // chop and sleep gates, both polarities
    wr(`CKG_CHOP_GATE_OFS, 32'h0000_0000);
    idle(2);
    chk("amp_on", {31'h0, amp_chop_clk_en}, 32'h1);
    chk("sleep_on", {31'h0, sleep_timer_clk_en}, 32'h1);
    wr(`CKG_CHOP_GATE_OFS, 32'h0000_0006);
    idle(2);
    chk("amp_off", {31'h0, amp_chop_clk_en}, 32'h0);
    chk("sleep_off", {31'h0, sleep_timer_clk_en}, 32'h0);
    rchk("chop_rd", `CKG_CHOP_GATE_OFS, 32'h0000_0006);
    // stable flags and interrupt: only crystal event enabled
    wr(`CKG_IRQ_CLEAR_OFS, 32'h0000_000f);
    wr(`CKG_IRQ_ENABLE_OFS, 32'h0000_0001);
    chk("irq_idle", {31'h0, irq}, 32'h0);
    crystal_ready <= 1'b1;
    idle(5);
    chk("irq_xtal", {31'h0, irq}, 32'h1);
    crystal_ready <= 1'b0;
    idle(3);
    rchk("xtal_flag", `CKG_OSC_CONTROL_OFS, 32'h0000_0407);
    wr(`CKG_IRQ_CLEAR_OFS, 32'h0000_0001);
    idle(2);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    hf_internal_ready <= 1'b1;
    lf_internal_ready <= 1'b1;
    idle(5);
    rchk("hf_lf_flag", `CKG_OSC_CONTROL_OFS, 32'h0000_0707);
    rchk("irq_status", `CKG_IRQ_STATUS_OFS, 32'h0000_0006);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(`CKG_IRQ_CLEAR_OFS, 32'h0000_000f);
    rchk("status_clr", `CKG_IRQ_STATUS_OFS, 32'h0000_0000);
    // losing ready keeps the flag; disabling clears it
    hf_internal_ready <= 1'b0;
    idle(3);
    rchk("hf_sticky", `CKG_OSC_CONTROL_OFS, 32'h0000_0707);
    wr(`CKG_UNLOCK_KEY_OFS, 32'h0000_cb14);
    wr(`CKG_OSC_CONTROL_OFS, 32'h0000_0003);
    idle(2);
    rchk("xtal_off", `CKG_OSC_CONTROL_OFS, 32'h0000_0303);
    chk("mapped_err", {31'h0, er}, 32'h0);
    chk("xtal_on_off", {31'h0, crystal_osc_on}, 32'h0);
    chk("hf_lf_kept", {30'h0, hf_internal_osc_on, lf_internal_osc_on}, 32'h3);
    complete_run();
  end
endmodule : tb_ckg_top
